//--- hw/adc_sample_ctrl.sv
// converter control: strap decode, sample timing, pipeline, output word and registers
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`default_nettype none
module adc_sample_ctrl #(
	parameter logic [adc_ctrl_pkg::REC_W-1:0] PD_RECOVER_CYCLES =
		adc_ctrl_pkg::PD_RECOVER_CYCLES_DFLT,
	parameter logic [adc_ctrl_pkg::REC_W-1:0] SLEEP_RECOVER_CYCLES =
		adc_ctrl_pkg::SLEEP_RECOVER_CYCLES_DFLT
) (
	input  wire logic                              clk_i,
	input  wire logic                              rst_b_i,
	input  wire logic                              sample_clk_p_i,
	input  wire logic                              sample_clk_n_i,
	input  wire logic [adc_ctrl_pkg::RAW_W-1:0]    analog_level_i,
	input  wire logic [1:0]                        power_state_select_pin_i,
	input  wire logic [1:0]                        clock_and_format_select_i,
	input  wire logic [adc_ctrl_pkg::ADDR_W-1:0]   reg_addr_i,
	input  wire logic [adc_ctrl_pkg::DATA_W-1:0]   reg_wdata_i,
	input  wire logic                              reg_wr_i,
	input  wire logic                              reg_rd_i,
	output var  logic [adc_ctrl_pkg::DATA_W-1:0]   reg_rdata_o,
	output var  logic [adc_ctrl_pkg::SAMPLE_W-1:0] sample_word_bits_o,
	output var  logic                              over_range_flag_o,
	output var  logic                              output_sample_strobe_o,
	output var  logic [1:0]                        spare_output_ground_o,
	output var  logic                              recovering_o,
	output var  logic                              irq_o
);
	import adc_ctrl_pkg::*;

	logic [PIN_W-1:0]          pins_s;
	logic                      clk_p_s;
	logic                      clk_n_s;
	logic [1:0]                pwr_s;
	logic [1:0]                cfs_s;
	logic signed [RAW_W-1:0]   raw_s;
	logic                      link_lvl_r;
	logic                      link_lvl_nxt;
	logic                      link_prev_r;
	logic                      rise;
	logic [PER_W-1:0]          per_cnt_r;
	logic [PER_W-1:0]          period_r;
	logic                      dcs_high_r;
	logic                      hold_pulse;
	logic                      stall_r;
	logic                      stall_hit;
	logic [SAMPLE_W-1:0]       held_r;
	logic                      held_ovr_r;
	logic                      held_valid_r;
	logic [SAMPLE_W-1:0]       clip_word;
	logic                      clip_ovr;
	conv_state_t               state_r;
	conv_state_t               state_nxt;
	logic [REC_W-1:0]          rec_cnt_r;
	logic [1:0]                pwr_prev_r;
	logic [1:0]                cfs_prev_r;
	logic                      pwr_chg;
	logic                      cfs_chg;
	logic                      run;
	logic                      flush;
	logic                      diff_mode;
	logic                      twos_fmt;
	logic [SAMPLE_W:0]         pd [0:PIPE_DEPTH];
	logic                      pv [0:PIPE_DEPTH];
	logic                      out_valid_r;
	logic [EV_W-1:0]           ev;
	logic [EV_W-1:0]           irq_stat_r;
	logic [EV_W-1:0]           irq_mask_r;
	logic [EV_W-1:0]           w1c;
	logic [DATA_W-1:0]         rd_sel;

	// every pin from outside the clk_i domain passes two flops first
	sync_2ff #(.W(PIN_W)) u_sync_pins (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.d_i     ({sample_clk_p_i, sample_clk_n_i, power_state_select_pin_i,
			clock_and_format_select_i, analog_level_i}),
		.q_o     (pins_s)
	);

	assign clk_p_s   = pins_s[PIN_W-1];
	assign clk_n_s   = pins_s[PIN_W-2];
	assign pwr_s     = pins_s[PIN_W-3:PIN_W-4];
	assign cfs_s     = pins_s[PIN_W-5:PIN_W-6];
	assign raw_s     = $signed(pins_s[RAW_W-1:0]);
	assign diff_mode = cfs_s[CFS_DIFF_BIT];
	assign twos_fmt  = cfs_s[CFS_TWOS_BIT];

	// differential mode follows only clean complementary states and holds
	// across an equal pair, so a glitch on one leg cannot make an edge
	assign link_lvl_nxt = !diff_mode ? clk_p_s :
		(clk_p_s && !clk_n_s) ? 1'b1 :
		(!clk_p_s && clk_n_s) ? 1'b0 : link_lvl_r;
	assign rise = link_lvl_r && !link_prev_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			link_lvl_r  <= 1'b0;
			link_prev_r <= 1'b0;
		end else begin
			link_lvl_r  <= link_lvl_nxt;
			link_prev_r <= link_lvl_r;
		end
	end

	// duty-cycle stabiliser: only rising edges count; the hold instant sits
	// half a measured period later, whatever the input duty cycle
	assign hold_pulse = dcs_high_r && !rise && (per_cnt_r == (period_r >> 1));
	assign stall_hit  = (per_cnt_r == CLK_STALL_CYCLES);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			per_cnt_r  <= '0;
			period_r   <= '0;
			dcs_high_r <= 1'b0;
			stall_r    <= 1'b0;
		end else if (rise) begin
			per_cnt_r  <= '0;
			period_r   <= per_cnt_r + 8'h01;
			dcs_high_r <= 1'b1;
			stall_r    <= 1'b0;
		end else begin
			if (!stall_hit)
				per_cnt_r <= per_cnt_r + 8'h01;
			if (hold_pulse || stall_hit)
				dcs_high_r <= 1'b0;
			if (stall_hit)
				stall_r <= 1'b1;
		end
	end

	// saturate the core value to the 12-bit range
	assign clip_ovr  = (raw_s > RAW_MAX) || (raw_s < RAW_MIN);
	assign clip_word = (raw_s > RAW_MAX) ? RAW_MAX[SAMPLE_W-1:0] :
		(raw_s < RAW_MIN) ? RAW_MIN[SAMPLE_W-1:0] : raw_s[SAMPLE_W-1:0];

	// track while the stabilised clock is high, freeze at its fall
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			held_r       <= '0;
			held_ovr_r   <= 1'b0;
			held_valid_r <= 1'b0;
		end else if (hold_pulse) begin
			held_r       <= clip_word;
			held_ovr_r   <= clip_ovr;
			held_valid_r <= run && !stall_r;
		end else if (flush) begin
			held_valid_r <= 1'b0;
		end
	end

	// power state sequencing; no reset pin exists on the part, so reset is
	// treated as a cold wake and pays the full power-down recovery
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_OFF, ST_SLEEP: begin
				if (pwr_s == PWR_ON)
					state_nxt = ST_RECOVER;
			end
			ST_RECOVER: begin
				if (rec_cnt_r == '0)
					state_nxt = ST_RUN;
			end
			ST_RUN: state_nxt = ST_RUN;
			default: state_nxt = ST_OFF;
		endcase
		if (pwr_s == PWR_SLEEP)
			state_nxt = ST_SLEEP;
		else if (pwr_s != PWR_ON)
			state_nxt = ST_OFF;
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_r   <= ST_RECOVER;
			rec_cnt_r <= PD_RECOVER_CYCLES;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_OFF)
				rec_cnt_r <= PD_RECOVER_CYCLES;
			else if (state_r == ST_SLEEP)
				rec_cnt_r <= SLEEP_RECOVER_CYCLES;
			else if (rec_cnt_r != '0)
				rec_cnt_r <= rec_cnt_r - 20'h00001;
		end
	end

	// strap changes and stalls void everything in flight
	assign pwr_chg = (pwr_s != pwr_prev_r);
	assign cfs_chg = (cfs_s != cfs_prev_r);
	assign run     = (state_r == ST_RUN);
	assign flush   = !run || (pwr_s != PWR_ON) || cfs_chg || stall_r;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pwr_prev_r <= PWR_ON;
			cfs_prev_r <= 2'h0;
		end else begin
			pwr_prev_r <= pwr_s;
			cfs_prev_r <= cfs_s;
		end
	end

	// conversion pipeline, one stage per sampling edge
	assign pd[0] = {held_ovr_r, held_r};
	assign pv[0] = held_valid_r;

	genvar gi;
	generate
		for (gi = 0; gi < PIPE_DEPTH; gi++) begin : g_pipe
			pipe_stage #(.W(SAMPLE_W + 1)) u_stage (
				.clk_i   (clk_i),
				.rst_b_i (rst_b_i),
				.adv_i   (rise),
				.flush_i (flush),
				.d_i     (pd[gi]),
				.valid_i (pv[gi]),
				.q_o     (pd[gi+1]),
				.valid_o (pv[gi+1])
			);
		end
	endgenerate

	// word and flag leave together; offset binary is the internal code with
	// its msb inverted. data change at a sampling edge and the strobe rises
	// one cycle later, so both strobe edges see settled data
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			sample_word_bits_o     <= '0;
			over_range_flag_o      <= 1'b0;
			out_valid_r            <= 1'b0;
			output_sample_strobe_o <= 1'b0;
		end else begin
			if (flush) begin
				sample_word_bits_o <= '0;
				over_range_flag_o  <= 1'b0;
				out_valid_r        <= 1'b0;
			end else if (rise) begin
				sample_word_bits_o <= {pd[PIPE_DEPTH][SAMPLE_W-1] ^ !twos_fmt,
					pd[PIPE_DEPTH][SAMPLE_W-2:0]};
				over_range_flag_o  <= pd[PIPE_DEPTH][SAMPLE_W];
				out_valid_r        <= pv[PIPE_DEPTH];
			end
			output_sample_strobe_o <= out_valid_r && dcs_high_r && !flush;
		end
	end

	// spare grounds stay low; recovering shows the inaccurate window
	assign spare_output_ground_o = 2'h0;
	assign recovering_o          = (state_r == ST_RECOVER);

	// sticky events: a new event wins over a write-one clear in the same cycle
	assign ev[EV_OVR]   = rise && !flush && pv[PIPE_DEPTH] && pd[PIPE_DEPTH][SAMPLE_W];
	assign ev[EV_PWR]   = pwr_chg;
	assign ev[EV_CFS]   = cfs_chg;
	assign ev[EV_READY] = (state_r == ST_RECOVER) && (state_nxt == ST_RUN);
	assign ev[EV_STALL] = stall_hit && !stall_r && !rise;
	assign w1c          = (reg_wr_i && reg_addr_i == REG_IRQ_STAT) ?
		reg_wdata_i[EV_W-1:0] : '0;
	assign irq_o        = |(irq_stat_r & irq_mask_r);

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			irq_stat_r <= '0;
			irq_mask_r <= IRQ_MASK_RST;
		end else begin
			irq_stat_r <= (irq_stat_r & ~w1c) | ev;
			if (reg_wr_i && reg_addr_i == REG_IRQ_MASK)
				irq_mask_r <= reg_wdata_i[EV_W-1:0];
		end
	end

	// read mux; unmapped offsets read zero, data only in the cycle after
	assign rd_sel =
		(reg_addr_i == REG_STATUS)   ? {22'h000000, state_r, recovering_o, stall_r,
			twos_fmt, diff_mode, pwr_s} :
		(reg_addr_i == REG_IRQ_STAT) ? {27'h0000000, irq_stat_r} :
		(reg_addr_i == REG_IRQ_MASK) ? {27'h0000000, irq_mask_r} :
		(reg_addr_i == REG_LAST)     ? {18'h00000, out_valid_r, over_range_flag_o,
			sample_word_bits_o} : 32'h00000000;

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i)
			reg_rdata_o <= '0;
		else
			reg_rdata_o <= reg_rd_i ? rd_sel : 32'h00000000;
	end

	// checks on the block's own behaviour
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_off_waking;
		(state_r == ST_OFF) && (pwr_s == PWR_ON);
	endsequence
	sequence s_recover_loaded;
		(state_r == ST_RECOVER) && (rec_cnt_r == PD_RECOVER_CYCLES);
	endsequence
	sequence s_strobe_rises;
		!output_sample_strobe_o ##1 output_sample_strobe_o;
	endsequence

	property p_pwr_decode;
		(pwr_s == PWR_SLEEP) |=> (state_r == ST_SLEEP) && !output_sample_strobe_o;
	endproperty
	a_pwr_decode: assert property (p_pwr_decode) else $error("sleep strap not obeyed");

	property p_quiet_when_off;
		!run |-> ##1 !out_valid_r ##1 !output_sample_strobe_o;
	endproperty
	a_quiet_when_off: assert property (p_quiet_when_off) else $error("output live while off");

	property p_pipe_lost;
		!run |=> !pv[PIPE_DEPTH] && !held_valid_r;
	endproperty
	a_pipe_lost: assert property (p_pipe_lost) else $error("pipeline kept data in low power");

	property p_recover_load;
		s_off_waking |=> s_recover_loaded;
	endproperty
	a_recover_load: assert property (p_recover_load) else $error("recovery count not loaded");

	property p_format;
		(rise && !flush) |=>
			(sample_word_bits_o[SAMPLE_W-1] == ($past(pd[PIPE_DEPTH][SAMPLE_W-1]) ^ !$past(twos_fmt)));
	endproperty
	a_format: assert property (p_format) else $error("output code format wrong");

	property p_dcs_half;
		$fell(dcs_high_r) && !$past(stall_hit) |->
			$past(per_cnt_r) == ($past(period_r) >> 1);
	endproperty
	a_dcs_half: assert property (p_dcs_half) else $error("hold not at half period");

	property p_clip;
		(hold_pulse && raw_s > RAW_MAX) |=> held_ovr_r && (held_r == RAW_MAX[SAMPLE_W-1:0]);
	endproperty
	a_clip: assert property (p_clip) else $error("over-range not flagged");

	property p_ovr_align;
		(rise && !flush) |=> over_range_flag_o == $past(pd[PIPE_DEPTH][SAMPLE_W]);
	endproperty
	a_ovr_align: assert property (p_ovr_align) else $error("flag split from its word");

	property p_strobe_data_stable;
		s_strobe_rises |-> $stable(sample_word_bits_o) && out_valid_r;
	endproperty
	a_strobe_data_stable: assert property (p_strobe_data_stable) else $error("data moved at strobe");

	property p_hold_capture;
		hold_pulse |=> held_r == $past(clip_word);
	endproperty
	a_hold_capture: assert property (p_hold_capture) else $error("held value not captured");

	property p_strap_flush;
		cfs_chg |=> !pv[1] && !out_valid_r;
	endproperty
	a_strap_flush: assert property (p_strap_flush) else $error("stale samples after strap change");
endmodule
`default_nettype wire

//--- hw/adc_ctrl_pkg.sv
// constants, field layouts and state codes shared by the converter control block
`default_nettype none
package adc_ctrl_pkg;
	// widths
	localparam int unsigned SAMPLE_W   = 12;
	localparam int unsigned RAW_W      = 14;
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned PER_W      = 8;
	localparam int unsigned REC_W      = 20;
	localparam int unsigned EV_W       = 5;
	localparam int unsigned PIPE_DEPTH = 4;
	localparam int unsigned PIN_W      = 20;

	// timing, each figure in its own unit, then as clk_i cycles
	localparam int unsigned CLK_PERIOD_NS     = 4;
	localparam int unsigned PD_RECOVER_MS     = 3;
	localparam int unsigned SLEEP_RECOVER_US  = 300;
	localparam int unsigned CLK_STALL_NS      = 256;
	localparam logic [REC_W-1:0] PD_RECOVER_CYCLES_DFLT =
		REC_W'((PD_RECOVER_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [REC_W-1:0] SLEEP_RECOVER_CYCLES_DFLT =
		REC_W'((SLEEP_RECOVER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [PER_W-1:0] CLK_STALL_CYCLES = PER_W'(CLK_STALL_NS / CLK_PERIOD_NS);

	// digitised strap levels of the power state select pin
	localparam logic [1:0] PWR_ON    = 2'h0;  // analog ground
	localparam logic [1:0] PWR_SLEEP = 2'h1;  // half supply
	localparam logic [1:0] PWR_DOWN  = 2'h2;  // full supply (3 also reads as down)

	// clock-and-format strap: bit 1 selects differential, bit 0 two's complement
	localparam int unsigned CFS_DIFF_BIT = 1;
	localparam int unsigned CFS_TWOS_BIT = 0;

	// conversion range of the 12-bit word, held internally as two's complement
	localparam logic signed [RAW_W-1:0] RAW_MAX = 14'sh07ff;
	localparam logic signed [RAW_W-1:0] RAW_MIN = 14'sh3800;

	// register offsets
	localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h00;
	localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h04;
	localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h08;
	localparam logic [ADDR_W-1:0] REG_LAST     = 8'h0c;
	localparam logic [EV_W-1:0]   IRQ_MASK_RST = 5'h00;

	// event bit positions in status and mask registers
	localparam int unsigned EV_OVR   = 0;
	localparam int unsigned EV_PWR   = 1;
	localparam int unsigned EV_CFS   = 2;
	localparam int unsigned EV_READY = 3;
	localparam int unsigned EV_STALL = 4;

	typedef enum logic [3:0] {
		ST_OFF     = 4'b0001,
		ST_SLEEP   = 4'b0010,
		ST_RECOVER = 4'b0100,
		ST_RUN     = 4'b1000
	} conv_state_t;
endpackage
`default_nettype wire

//--- hw/sync_2ff.sv
// two flip-flop synchroniser for a group of pins
`default_nettype none
module sync_2ff #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;

	// the first stage is read by the second only
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- hw/pipe_stage.sv
// one conversion pipeline stage: word plus valid, advanced per sampling edge
`default_nettype none
module pipe_stage #(
	parameter int unsigned W = 13
) (
	input  wire logic         clk_i,
	input  wire logic         rst_b_i,
	input  wire logic         adv_i,
	input  wire logic         flush_i,
	input  wire logic [W-1:0] d_i,
	input  wire logic         valid_i,
	output var  logic [W-1:0] q_o,
	output var  logic         valid_o
);
	// a flush beats an advance so stale samples never reappear
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			q_o     <= '0;
			valid_o <= 1'b0;
		end else if (flush_i) begin
			valid_o <= 1'b0;
		end else if (adv_i) begin
			q_o     <= d_i;
			valid_o <= valid_i;
		end
	end
endmodule
`default_nettype wire

//--- tb/adc_capture_partner.sv
// receiving-side model: sampling clock source and output word capture
`default_nettype none
module adc_capture_partner (
	input  wire logic        clk_i,
	input  wire logic        run_i,
	input  var  int          hi_ns_i,
	input  wire logic [1:0]  clock_and_format_select_i,
	input  wire logic        recovering_i,
	input  wire logic [11:0] sample_word_bits_i,
	input  wire logic        over_range_flag_i,
	input  wire logic        output_sample_strobe_i,
	output var  logic        sample_clk_p_o,
	output var  logic        sample_clk_n_o,
	output var  logic [12:0] rise_cap_o,
	output var  logic [12:0] fall_cap_o,
	output var  int          cap_cnt_o,
	output var  int          rise_cnt_o
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       strobe_q = 1'b0;
	logic [1:0] cfs_q    = 2'h0;
	int         skip     = 5;

	// 32 ns period; stands low while stopped so a stall is a real stall
	initial begin
		sample_clk_p_o = 1'b0;
		cap_cnt_o      = 0;
		rise_cnt_o     = 0;
		#1.3;
		forever begin
			if (run_i) begin
				sample_clk_p_o = 1'b1;
				#(hi_ns_i);
				sample_clk_p_o = 1'b0;
				#(32 - hi_ns_i);
			end else begin
				#4;
			end
		end
	end

	// complementary leg when differential, tied to ground when single-ended
	assign sample_clk_n_o = clock_and_format_select_i[1] ? ~sample_clk_p_o : 1'b0;

	// spare ground pins are not even wired to this model
	// latch on both strobe edges; skip words until the pipeline has refilled
	always @(posedge clk_i) begin
		strobe_q <= output_sample_strobe_i;
		cfs_q    <= clock_and_format_select_i;
		if (output_sample_strobe_i && !strobe_q) begin
			rise_cap_o <= {over_range_flag_i, sample_word_bits_i};
			rise_cnt_o <= rise_cnt_o + 1;
			if (skip > 0)
				skip <= skip - 1;
			else
				cap_cnt_o <= cap_cnt_o + 1;
		end
		if (!output_sample_strobe_i && strobe_q)
			fall_cap_o <= {over_range_flag_i, sample_word_bits_i};
		if (recovering_i || clock_and_format_select_i != cfs_q)
			skip <= 5;
	end
endmodule
`default_nettype wire

//--- tb/adc_mode_strap_and_sample_output_tb_top.sv
// self-checking bench for the converter control block
`default_nettype none
module adc_mode_strap_and_sample_output_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import adc_ctrl_pkg::*;
	localparam int REC_DOWN  = 40;
	localparam int REC_SLEEP = 20;
	logic              clk_i   = 1'b0;
	logic              rst_b_i = 1'b0;
	logic [RAW_W-1:0]  level   = 14'h0000;
	logic [1:0]        pwr     = 2'h0;
	logic [1:0]        cfs     = 2'h0;
	logic [ADDR_W-1:0] addr    = 8'h00;
	logic [DATA_W-1:0] wdata   = 32'h0;
	logic              wr      = 1'b0;
	logic              rd      = 1'b0;
	logic              run     = 1'b1;
	int                hi_ns   = 16;
	logic [DATA_W-1:0] rdata;
	logic [11:0]       word;
	logic              over;
	logic              strobe;
	logic              recov;
	logic              irq;
	logic [1:0]        spare;
	logic              clk_p;
	logic              clk_n;
	logic [12:0]       rise_cap;
	logic [12:0]       fall_cap;
	int                cap_cnt;
	int                rise_cnt;
	int                err_total       = 0;
	int                samples_checked = 0;
	int                cyc             = 0;
	int                seed            = 32'h212b3edc;
	int                vals[6]         = '{0, 2047, 2048, -2048, -2049, 1024};

	adc_sample_ctrl #(
		.PD_RECOVER_CYCLES    (REC_W'(REC_DOWN)),
		.SLEEP_RECOVER_CYCLES (REC_W'(REC_SLEEP))
	) i_dut (
		.clk_i (clk_i), .rst_b_i (rst_b_i), .sample_clk_p_i (clk_p), .sample_clk_n_i (clk_n),
		.analog_level_i (level), .power_state_select_pin_i (pwr),
		.clock_and_format_select_i (cfs), .reg_addr_i (addr), .reg_wdata_i (wdata),
		.reg_wr_i (wr), .reg_rd_i (rd), .reg_rdata_o (rdata), .sample_word_bits_o (word),
		.over_range_flag_o (over), .output_sample_strobe_o (strobe),
		.spare_output_ground_o (spare), .recovering_o (recov), .irq_o (irq)
	);

	adc_capture_partner i_partner (
		.clk_i (clk_i), .run_i (run), .hi_ns_i (hi_ns), .clock_and_format_select_i (cfs),
		.recovering_i (recov), .sample_word_bits_i (word), .over_range_flag_i (over),
		.output_sample_strobe_i (strobe), .sample_clk_p_o (clk_p), .sample_clk_n_o (clk_n),
		.rise_cap_o (rise_cap), .fall_cap_o (fall_cap), .cap_cnt_o (cap_cnt),
		.rise_cnt_o (rise_cnt)
	);

	// 250 MHz system clock
	initial begin
		forever #2 clk_i = ~clk_i;
	end

	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// hang guard, well above the few thousand cycles the tests need
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 40000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_word(input string what, input logic [12:0] exp, input logic [12:0] got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask

	// read data stands only in the cycle after the read edge
	task automatic reg_rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge clk_i);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// reference code: clamp to 12 bits, msb flipped for offset binary
	function automatic logic [12:0] expect_word(input int v, input logic twos);
		int          c;
		logic [11:0] w;
		c = (v > 2047) ? 2047 : ((v < -2048) ? -2048 : v);
		w = c[11:0];
		if (!twos)
			w[11] = ~w[11];
		return {logic'(v > 2047 || v < -2048), w};
	endfunction

	// hold a level long enough for the pipeline to flush old samples
	task automatic convert(input int v);
		int                base;
		int                n;
		logic [12:0]       exp;
		logic [DATA_W-1:0] d;
		@(posedge clk_i);
		exp = expect_word(v, cfs[CFS_TWOS_BIT]);
		level <= RAW_W'(v);
		base = cap_cnt;
		n = 0;
		while (cap_cnt < base + 7 && n < 400) begin
			@(posedge clk_i);
			n++;
		end
		chk("capture_count", 32'h1, 32'(cap_cnt >= base + 7));
		chk_word("rise_capture", exp, rise_cap);
		chk_word("fall_capture", exp, fall_cap);
		reg_rd(REG_LAST, d);
		chk("last_word", {18'h0, 1'b1, exp}, d);
	endtask

	// recovery must last its count and stay free of strobes
	task automatic wait_rec(input int len);
		int n;
		int r0;
		n = 0;
		r0 = rise_cnt;
		while (recov !== 1'b1 && n < 10) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		n = 0;
		while (recov === 1'b1 && n < len + 20) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("recovery_length", 32'h1, 32'(n >= len - 4 && n <= len + 4));
		chk("strobes_in_recovery", 32'(r0), 32'(rise_cnt));
	endtask

	initial begin
		logic [DATA_W-1:0] d;
		int                n;
		repeat (10) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		#1;
		chk("recovering_at_reset", 32'h1, 32'(recov));
		chk("strobe_at_reset", 32'h0, 32'(strobe));
		chk("spare_ground", 32'h0, 32'(spare));
		reg_rd(REG_STATUS, d);
		chk("status_state", 32'h4, 32'(d[9:6]));
		reg_rd(REG_IRQ_MASK, d);
		chk("mask_reset", 32'h0, d);
		reg_rd(8'h10, d);
		chk("unmapped_read", 32'h0, d);
		// seven cycles of the recovery were already spent on the reads above
		wait_rec(REC_DOWN - 7);
		$display("test reset done");
		// every strap code, duty near both stabiliser limits
		for (int m = 0; m < 4; m++) begin
			@(posedge clk_i);
			cfs   <= 2'(m);
			hi_ns <= m[0] ? 10 : 22;
			for (int k = 0; k < 6; k++)
				convert(vals[k]);
			convert($random(seed) % 3000);
			reg_rd(REG_STATUS, d);
			chk("status_mode", {30'h0, m[0], m[1]}, 32'(d[3:2]));
		end
		$display("test formats done");
		for (int p = 0; p < 2; p++) begin
			@(posedge clk_i);
			pwr <= p ? PWR_SLEEP : PWR_DOWN;
			repeat (40) @(posedge clk_i);
			n = rise_cnt;
			repeat (40) @(posedge clk_i);
			#1;
			chk("strobes_while_off", 32'(n), 32'(rise_cnt));
			chk("word_while_off", 32'h0, 32'(word));
			reg_rd(REG_STATUS, d);
			chk("status_power", p ? 32'h2 : 32'h1, 32'(d[9:6]));
			chk("status_strap", p ? 32'h1 : 32'h2, 32'(d[1:0]));
			@(posedge clk_i);
			pwr <= PWR_ON;
			wait_rec(p ? REC_SLEEP : REC_DOWN);
			convert(-2048);
		end
		$display("test power done");
		reg_rd(REG_IRQ_STAT, d);
		chk("irq_events", 32'h0f, d & 32'h0f);
		chk("irq_masked", 32'h0, 32'(irq));
		reg_wr(REG_IRQ_MASK, 32'(1 << EV_PWR));
		@(posedge clk_i);
		#1;
		chk("irq_unmasked", 32'h1, 32'(irq));
		reg_rd(REG_IRQ_MASK, d);
		chk("mask_readback", 32'h2, d);
		reg_wr(REG_IRQ_STAT, 32'(1 << EV_PWR));
		reg_rd(REG_IRQ_STAT, d);
		chk("irq_bit_cleared", 32'h0, 32'(d[EV_PWR]));
		chk("irq_cleared", 32'h0, 32'(irq));
		$display("test interrupts done");
		@(posedge clk_i);
		run <= 1'b0;
		repeat (100) @(posedge clk_i);
		#1;
		chk("strobe_in_stall", 32'h0, 32'(strobe));
		reg_rd(REG_IRQ_STAT, d);
		chk("stall_event", 32'h1, 32'(d[EV_STALL]));
		@(posedge clk_i);
		run <= 1'b1;
		convert(2047);
		$display("test stall done");
		end_sim();
	end
endmodule
`default_nettype wire
